// ==== logic/pdcap_pkg.sv ====
// Package for the pulse duration capture block: constants, encodings and carriers
`default_nettype none
package pdcap_pkg;
   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned CNT_W           = 16;
   localparam int unsigned PRESC_W         = 4;
   localparam logic [1:0]  MODE_BOTH0      = 2'h0;
   localparam logic [1:0]  MODE_BOTH1      = 2'h1;
   localparam logic [1:0]  MODE_RISE       = 2'h2;
   localparam logic [1:0]  MODE_FALL       = 2'h3;
   localparam logic [15:0] CNT_RESET       = 16'h0000;
   localparam logic [15:0] CNT_MAX         = 16'hFFFF;
   localparam logic [3:0]  PRESC_RESET     = 4'h0;
   localparam logic [14:0] DIV_RESET       = 15'h0000;
   localparam int unsigned BUF_DEPTH       = 2;

   // Mode configuration word
   typedef struct packed {
      logic       single_measurement;
      logic       overrun_policy;
      logic [1:0] edge_selection_field;
      logic [3:0] prescaler;
   } pdcap_mode_t;

   localparam pdcap_mode_t MODE_RESET = '0;

   // One-cycle commands
   typedef struct packed {
      logic start_measure_command;
      logic disable_command;
      logic enable_command;
      logic soft_reset_command;
   } pdcap_cmd_t;

   // Status view
   typedef struct packed {
      logic enabled_status_flag;
      logic new_value_flag;
      logic overflow;
      logic overrun;
      logic dma_complete_flag;
   } pdcap_status_t;

   // Clear-status strobes
   typedef struct packed {
      logic overflow;
      logic overrun;
      logic dma_complete_flag;
   } pdcap_clear_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM  = 3'b010,
      ST_RUN  = 3'b100
   } pdcap_state_t;
endpackage : pdcap_pkg
`default_nettype wire

// ==== logic/pdcap_buf.sv ====
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module pdcap_buf (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        flush,
   input  wire logic        in_valid,
   output logic             in_ready,
   input  wire logic [15:0] in_data,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic [15:0]      out_data
);
   logic [15:0] mem_q [pdcap_pkg::BUF_DEPTH];
   logic        wp_q;
   logic        rp_q;
   logic [1:0]  cnt_q;
   wire         push = in_valid && in_ready;
   wire         pop  = out_valid && out_ready;

   assign in_ready  = (cnt_q != 2'h2);
   assign out_valid = (cnt_q != 2'h0);
   assign out_data  = mem_q[rp_q];

   always_ff @(posedge clk) begin
      if (!rst_n || flush) begin
         wp_q  <= 1'b0;
         rp_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) wp_q <= ~wp_q;
         if (pop) rp_q <= ~rp_q;
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_q[wp_q] <= in_data;
   end
endmodule : pdcap_buf
`default_nettype wire

// ==== logic/pdcap_top.sv ====
// Pulse duration capture: prescaled edge timer with result buffer toward the DMA channel
//
// What this block does
// - Measure high and low durations in count_clock cycles into result register.
// - Offer each result to the DMA channel as one 16-bit word; a result that finds the buffer full is dropped.
// - Catch every edge below count_clock/2, error at most one period.
// - Three modes: either edge, rising to rising, falling to falling.
// - Edge selection value 0x2 measures rising to rising periods.
// - Overrun either overwrites the unread result or stops acquiring, per policy.
// - Reading the result register clears the new value flag.
// - Disabling capture resets the duration counter.
// - Prescaler zero gives count_clock at half the core clock.
// - Prescaler halves count_clock per step, from core/2 at 0 down to core/32768 at 14 and 15.
// - Each edge detected within one count_clock period.
// - Edge delay at most one, duration error at most two periods.
// - Enable command raises enabled flag; start only after it reads set.
// - DMA transfer complete sets the DMA complete flag; interrupt if enabled.
// - Clock gate lets software stop the count clock to save power.
// - Single measurement mode stops after one result until next start.
// - Soft reset clears all state except the clock gate status and the input synchroniser.
`default_nettype none
module pdcap_top (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     sig_in,
   input  wire logic                     clock_gate_on,
   input  wire logic                     clock_gate_off,
   input  wire pdcap_pkg::pdcap_cmd_t    cmd,
   input  wire logic                     mode_we,
   input  wire pdcap_pkg::pdcap_mode_t   mode_wdata,
   input  wire pdcap_pkg::pdcap_clear_t  clear,
   input  wire logic [2:0]               irq_enable_set,
   input  wire logic [2:0]               irq_enable_clr,
   input  wire logic                     result_rd,
   input  wire logic                     dma_ready,
   input  wire logic                     dma_done,
   output pdcap_pkg::pdcap_mode_t        mode_q,
   output pdcap_pkg::pdcap_status_t      status_q,
   output logic                          clock_gate_status_q,
   output logic [15:0]                   result_q,
   output logic [2:0]                    irq_mask_q,
   output logic                          irq_q,
   output logic                          dma_valid_q,
   output logic [15:0]                   dma_data_q
);
   ////////////////////////////////////////////////////////////////////////////
   // Input synchroniser and count_clock divider

   logic        sig_m_q;
   logic        sig_s_q;
   logic        sig_p_q;
   logic [14:0] div_q;
   logic        enable_q;
   pdcap_pkg::pdcap_state_t state_q;
   logic [15:0] cnt_q;
   logic        cnt_sat_q;
   logic        stopped_q;

   wire sw_rst = cmd.soft_reset_command;
   wire srst   = !rst_n || sw_rst;

   // Tap select: fires when d[p:0] are all ones, once per 2^(p+1) core cycles
   // Limitation: prescaler 15 runs at the prescaler 14 rate, the divider has 15 bits
   function automatic logic div_tap(input logic [14:0] d, input logic [3:0] p);
      logic [15:0] ext;
      logic [15:0] msk;
      ext = {d, 1'b1};
      msk = (16'h0004 << p) - 16'h0001;
      div_tap = ((ext & msk) == msk);
   endfunction : div_tap

   wire tick = clock_gate_status_q && div_tap(div_q, mode_q.prescaler);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sig_m_q <= 1'b0;
         sig_s_q <= 1'b0;
      end else begin
         sig_m_q <= sig_in;
         sig_s_q <= sig_m_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !clock_gate_status_q) div_q <= pdcap_pkg::DIV_RESET;
      else div_q <= div_q + 15'h0001;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) clock_gate_status_q <= 1'b0;
      else if (clock_gate_off) clock_gate_status_q <= 1'b0;
      else if (clock_gate_on) clock_gate_status_q <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge detection on count_clock ticks

   wire rise = tick && sig_s_q && !sig_p_q;
   wire fall = tick && !sig_s_q && sig_p_q;
   wire term_edge = (mode_q.edge_selection_field == pdcap_pkg::MODE_RISE) ? rise :
                    (mode_q.edge_selection_field == pdcap_pkg::MODE_FALL) ? fall :
                    (rise || fall);

   always_ff @(posedge clk) begin
      if (srst) sig_p_q <= 1'b0;
      else if (tick) sig_p_q <= sig_s_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control: enable and measurement sequencing

   wire en_d = cmd.disable_command ? 1'b0 : (cmd.enable_command ? 1'b1 : enable_q);

   always_ff @(posedge clk) begin
      if (srst) enable_q <= 1'b0;
      else enable_q <= en_d;
   end

   always_ff @(posedge clk) begin
      if (srst) mode_q <= pdcap_pkg::MODE_RESET;
      else if (mode_we) mode_q <= mode_wdata;
   end

   logic overrun_block;
   wire overrun_evt = stopped_q && term_edge && state_q == pdcap_pkg::ST_RUN;
   wire capture     = term_edge && state_q == pdcap_pkg::ST_RUN && !overrun_block;
   assign overrun_block = status_q.new_value_flag && !mode_q.overrun_policy;

   pdcap_pkg::pdcap_state_t state_d;
   always_comb begin
      state_d = state_q;
      case (state_q)
         pdcap_pkg::ST_IDLE: if (cmd.start_measure_command && enable_q) state_d = pdcap_pkg::ST_ARM;
         // First selected edge opens the interval
         pdcap_pkg::ST_ARM:  if (term_edge) state_d = pdcap_pkg::ST_RUN;
         pdcap_pkg::ST_RUN:  if (capture && mode_q.single_measurement) state_d = pdcap_pkg::ST_IDLE;
         default:            state_d = pdcap_pkg::ST_IDLE;
      endcase
      if (!enable_q) state_d = pdcap_pkg::ST_IDLE;
   end

   always_ff @(posedge clk) begin
      if (srst) state_q <= pdcap_pkg::ST_IDLE;
      else state_q <= state_d;
   end

   assign stopped_q = overrun_block;

   ////////////////////////////////////////////////////////////////////////////
   // Duration counter

   always_ff @(posedge clk) begin
      if (srst || !enable_q || state_q != pdcap_pkg::ST_RUN || term_edge) begin
         // A disabled or resetting block never restarts the count
         cnt_q     <= (term_edge && enable_q && !srst) ? 16'h0001 : pdcap_pkg::CNT_RESET;
         cnt_sat_q <= 1'b0;
      end else if (tick) begin
         if (cnt_q == pdcap_pkg::CNT_MAX) cnt_sat_q <= 1'b1;
         else cnt_q <= cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result register, status and buffer toward the DMA channel

   wire         buf_in_ready;
   wire         buf_out_valid;
   wire [15:0]  buf_out_data;
   wire         ovf_evt = tick && cnt_q == pdcap_pkg::CNT_MAX && !cnt_sat_q && state_q == pdcap_pkg::ST_RUN;

   always_ff @(posedge clk) begin
      if (srst) result_q <= pdcap_pkg::CNT_RESET;
      else if (capture) result_q <= cnt_q;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         status_q <= '0;
      end else begin
         status_q.enabled_status_flag <= en_d;
         status_q.new_value_flag <= capture || (status_q.new_value_flag && !result_rd);
         // Full buffer drops the word, so it counts as an overrun too
         status_q.overrun <= (overrun_evt || (capture && status_q.new_value_flag && !result_rd)
                              || (capture && !buf_in_ready))
                             || (status_q.overrun && !clear.overrun);
         status_q.overflow <= ovf_evt || (status_q.overflow && !clear.overflow);
         status_q.dma_complete_flag <= dma_done || (status_q.dma_complete_flag && !clear.dma_complete_flag);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) irq_mask_q <= 3'h0;
      else irq_mask_q <= (irq_mask_q | irq_enable_set) & ~irq_enable_clr;
   end

   always_ff @(posedge clk) begin
      if (srst) irq_q <= 1'b0;
      else irq_q <= |(irq_mask_q & {status_q.overflow, status_q.overrun, status_q.dma_complete_flag});
   end

   pdcap_buf u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .flush     (sw_rst),
      .in_valid  (capture),
      .in_ready  (buf_in_ready),
      .in_data   (cnt_q),
      .out_valid (buf_out_valid),
      .out_ready (dma_ready || !dma_valid_q),
      .out_data  (buf_out_data)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         dma_valid_q <= 1'b0;
         dma_data_q  <= pdcap_pkg::CNT_RESET;
      end else if (dma_ready || !dma_valid_q) begin
         dma_valid_q <= buf_out_valid;
         dma_data_q  <= buf_out_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   wire div_quiet = !sw_rst && !mode_we && !clock_gate_off;

   sequence s_enable_cmd;
      cmd.enable_command && !cmd.disable_command && !sw_rst;
   endsequence

   a_enable_flag: assert property (@(posedge clk) disable iff (!rst_n)
      s_enable_cmd |=> status_q.enabled_status_flag)
      else $error("enabled flag not raised");
   a_disable_wins: assert property (@(posedge clk) disable iff (!rst_n)
      cmd.disable_command |=> !status_q.enabled_status_flag)
      else $error("disable did not win");
   a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
      result_rd && !capture && !sw_rst |=> !status_q.new_value_flag)
      else $error("read did not clear new value");
   a_capture_sets: assert property (@(posedge clk) disable iff (!rst_n)
      capture && !sw_rst |=> status_q.new_value_flag && result_q == $past(cnt_q))
      else $error("capture result missing");
   a_cnt_disabled: assert property (@(posedge clk) disable iff (!rst_n)
      !enable_q |=> cnt_q == pdcap_pkg::CNT_RESET)
      else $error("counter not reset while disabled");
   a_stop_policy: assert property (@(posedge clk) disable iff (!rst_n)
      status_q.new_value_flag && !mode_q.overrun_policy && !sw_rst |=> $stable(result_q))
      else $error("result overwritten under stop policy");
   a_single_shot: assert property (@(posedge clk) disable iff (!rst_n)
      capture && mode_q.single_measurement && !sw_rst |=> state_q == pdcap_pkg::ST_IDLE)
      else $error("single shot did not stop");
   a_gate_kept: assert property (@(posedge clk) disable iff (!rst_n)
      sw_rst && !clock_gate_on && !clock_gate_off |=> clock_gate_status_q == $past(clock_gate_status_q))
      else $error("gate status lost on soft reset");
   a_tick_rate: assert property (@(posedge clk) disable iff (!rst_n)
      tick && mode_q.prescaler == 4'h0 && div_quiet ##1 div_quiet |-> !tick ##1 tick)
      else $error("prescaler zero not half rate");
   a_dma_done: assert property (@(posedge clk) disable iff (!rst_n)
      dma_done && !sw_rst |=> status_q.dma_complete_flag)
      else $error("dma complete not set");
endmodule : pdcap_top
`default_nettype wire

// ==== dv/pdcap_sig_model.sv ====
// External signal model: square wave with chosen high and low lengths
`default_nettype none
module pdcap_sig_model (
   input  wire logic        clk,
   input  wire logic        run,
   input  wire logic [15:0] high_cyc,
   input  wire logic [15:0] low_cyc,
   output logic             sig
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] cnt_q;
   ////////////////////////////////////////////////////////////////
   // levels stay long
   always_ff @(posedge clk) begin
      if (!run) begin
         sig   <= 1'b0;
         cnt_q <= 16'h0001;
      end else if (cnt_q >= (sig ? high_cyc : low_cyc)) begin
         sig   <= ~sig;
         cnt_q <= 16'h0001;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule : pdcap_sig_model
`default_nettype wire

// ==== dv/pdcap_top_test.sv ====
// Self-checking bench for the pulse duration capture block
`default_nettype none
module pdcap_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, sig_in, g_on = 1'b0, g_off = 1'b0, mode_we = 1'b0;
   logic result_rd = 1'b0, dma_ready = 1'b0, dma_done = 1'b0, sig_run = 1'b0, stall_all = 1'b0;
   logic [2:0] ie_set = 3'h0, ie_clr = 3'h0, irq_mask_q;
   logic [15:0] high_cyc = 16'h0004, low_cyc = 16'h0004, result_q, dma_data_q, held;
   logic clock_gate_status_q, irq_q, dma_valid_q;
   pdcap_pkg::pdcap_cmd_t    cmd = '0;
   pdcap_pkg::pdcap_mode_t   mode_wdata = '0, mode_q;
   pdcap_pkg::pdcap_clear_t  clr = '0;
   pdcap_pkg::pdcap_status_t status_q;
   logic [15:0] exp_q[$];
   int errors = 0, cmp_count = 0;

   pdcap_top pdcap_top_inst (.clk(clk), .rst_n(rst_n), .sig_in(sig_in), .clock_gate_on(g_on),
      .clock_gate_off(g_off), .cmd(cmd), .mode_we(mode_we), .mode_wdata(mode_wdata), .clear(clr),
      .irq_enable_set(ie_set), .irq_enable_clr(ie_clr), .result_rd(result_rd), .dma_ready(dma_ready),
      .dma_done(dma_done), .mode_q(mode_q), .status_q(status_q), .clock_gate_status_q(clock_gate_status_q),
      .result_q(result_q), .irq_mask_q(irq_mask_q), .irq_q(irq_q), .dma_valid_q(dma_valid_q),
      .dma_data_q(dma_data_q));
   pdcap_sig_model pdcap_sig_model_inst (.clk(clk), .run(sig_run), .high_cyc(high_cyc),
      .low_cyc(low_cyc), .sig(sig_in));

   always #50 clk = ~clk;

   task automatic report_and_stop;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   task automatic check_word(input logic [15:0] exp, input logic [15:0] got, input int tol);
      logic ok;
      ok = 1'b0;
      cmp_count++;
      for (int d = -tol; d <= tol; d++)
         if (got === exp + 16'(d))
            ok = 1'b1;
      if (!ok) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check_word

   task automatic check_flag(input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : check_flag

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #10;
   endtask : tick

   ////////////////////////////////////////////////////////////////
   // Stalling receiver and result monitor
   always @(posedge clk) begin
      dma_ready <= #10 !stall_all && ($urandom_range(1, 0) == 1);
      if (rst_n && dma_valid_q && dma_ready) begin
         if (exp_q.size() == 0)
            check_word(16'hFFFF, dma_data_q, 0);
         else
            check_word(exp_q.pop_front(), dma_data_q, 2);
      end
   end

   task automatic setup(input logic [1:0] m, input logic [3:0] p, input logic one, input logic pol);
      int i;
      sig_run = 1'b0;
      cmd.soft_reset_command = 1'b1;
      tick();
      cmd = '0;
      mode_wdata = '{single_measurement: one, overrun_policy: pol, edge_selection_field: m, prescaler: p};
      mode_we = 1'b1;
      tick();
      mode_we = 1'b0;
      cmd.disable_command = 1'b1;
      tick();
      cmd = '0;
      check_word({8'h00, mode_q}, {8'h00, mode_wdata}, 0);
      cmd.enable_command = 1'b1;
      tick();
      cmd = '0;
      for (i = 0; i < 20 && status_q.enabled_status_flag !== 1'b1; i++)
         tick();
      check_flag(1'b1, status_q.enabled_status_flag);
      if (i == 20)
         report_and_stop();
      cmd.start_measure_command = 1'b1;
      tick();
      cmd = '0;
   endtask : setup

   task automatic measure(input logic [1:0] m);
      int p, kh, kl, i;
      p = $urandom_range(1, 0);
      kh = $urandom_range(20, 3);
      kl = (m < 2) ? kh : $urandom_range(20, 3);
      high_cyc = 16'((2 << p) * kh);
      low_cyc = 16'((2 << p) * kl);
      setup(m, 4'(p), 1'b1, 1'b1);
      exp_q.push_back(16'((m < 2) ? kh : kh + kl));
      sig_run = 1'b1;
      for (i = 0; i < 3000 && exp_q.size() != 0; i++)
         tick();
      if (i == 3000) begin
         errors++;
         report_and_stop();
      end
      tick(400);
   endtask : measure

   initial begin
      void'($urandom(47));
      tick(3);
      rst_n = 1'b1;
      g_on = 1'b1;
      tick();
      g_on = 1'b0;
      tick();
      check_flag(1'b1, clock_gate_status_q);
      for (int m = 0; m < 4; m++)
         measure(2'(m));
      stall_all = 1'b1;
      for (int pol = 0; pol < 2; pol++) begin
         high_cyc = 16'h0008;
         low_cyc = 16'h000A;
         setup(pdcap_pkg::MODE_RISE, 4'h0, 1'b0, 1'(pol));
         sig_run = 1'b1;
         tick(200);
         check_flag(1'b1, status_q.overrun);
         held = result_q;
         high_cyc = 16'h0014;
         tick(200);
         check_word(pol ? 16'h000F : held, result_q, pol ? 2 : 0);
      end
      ie_set = 3'h2;
      tick();
      ie_set = 3'h0;
      tick(2);
      check_flag(1'b1, irq_q);
      sig_run = 1'b0;
      tick(60);
      result_rd = 1'b1;
      clr.overrun = 1'b1;
      tick();
      result_rd = 1'b0;
      clr = '0;
      tick(2);
      check_flag(1'b0, status_q.new_value_flag);
      check_flag(1'b0, irq_q);
      dma_done = 1'b1;
      ie_set = 3'h1;
      tick();
      dma_done = 1'b0;
      ie_set = 3'h0;
      tick(2);
      check_flag(1'b1, status_q.dma_complete_flag);
      check_flag(1'b1, irq_q);
      cmd.disable_command = 1'b1;
      tick();
      cmd = '0;
      tick();
      check_flag(1'b0, status_q.enabled_status_flag);
      cmd.soft_reset_command = 1'b1;
      tick();
      cmd = '0;
      tick(2);
      check_word({8'h00, mode_q}, 16'h0000, 0);
      check_word({13'h0000, irq_mask_q}, 16'h0000, 0);
      check_flag(1'b1, clock_gate_status_q);
      stall_all = 1'b0;
      g_off = 1'b1;
      tick();
      g_off = 1'b0;
      tick(20);
      check_flag(1'b0, clock_gate_status_q);
      report_and_stop();
   end
endmodule : pdcap_top_test
`default_nettype wire
